// *** dts_pkg.sv ***
// shared constants, field layouts and timing figures for the ddr3 setup block
`default_nettype none
package dts_pkg;
    // system clock period in picoseconds (250 mhz)
    localparam int HCLK_PS = 4000;

    // least-time conversion: round up to whole hclk cycles, never below one
    function automatic int ps2cyc(input int ps);
        int c;
        c = (ps + HCLK_PS - 1) / HCLK_PS;
        return (c < 1) ? 1 : c;
    endfunction

    // speed grades
    typedef enum logic [1:0] {
        DTS_G1866 = 2'h0,
        DTS_G1600 = 2'h1,
        DTS_G1333 = 2'h2
    } dts_grade_t;

    // core delays in picoseconds, as printed in ns
    localparam int TRCD_1866_PS = 13910;
    localparam int TRCD_1600_PS = 13750;
    localparam int TRCD_1333_PS = 13500;
    localparam int TDOWNBIN_PS  = 13125;
    localparam int TRC_1866_PS  = 47910;
    localparam int TRC_1600_PS  = 48750;
    localparam int TRC_1333_PS  = 49500;
    localparam int TRAS_1600_PS = 35000;
    localparam int TRAS_1333_PS = 36000;
    localparam int TREFI_NS     = 7800;
    localparam int TRAS_REFI_N  = 9;

    // same delays as hclk cycle counts
    localparam logic [15:0] CYC_RCD_1866 = 16'(ps2cyc(TRCD_1866_PS));
    localparam logic [15:0] CYC_RCD_1600 = 16'(ps2cyc(TRCD_1600_PS));
    localparam logic [15:0] CYC_RCD_1333 = 16'(ps2cyc(TRCD_1333_PS));
    localparam logic [15:0] CYC_DOWNBIN  = 16'(ps2cyc(TDOWNBIN_PS));
    localparam logic [15:0] CYC_RC_1866  = 16'(ps2cyc(TRC_1866_PS));
    localparam logic [15:0] CYC_RC_1600  = 16'(ps2cyc(TRC_1600_PS));
    localparam logic [15:0] CYC_RC_1333  = 16'(ps2cyc(TRC_1333_PS));
    localparam logic [15:0] CYC_RAS_1600 = 16'(ps2cyc(TRAS_1600_PS));
    localparam logic [15:0] CYC_RAS_1333 = 16'(ps2cyc(TRAS_1333_PS));
    // longest time rounds down
    localparam int TRAS_MAX_CYC_DEF = TRAS_REFI_N * TREFI_NS * 1000 / HCLK_PS;
    localparam logic [15:0] CNT_SAT = 16'hffff;

    // register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_MR0  = 8'h04;
    localparam logic [7:0] OFS_MR1  = 8'h08;
    localparam logic [7:0] OFS_MR2  = 8'h0c;
    localparam logic [7:0] OFS_STS  = 8'h10;
    localparam logic [7:0] OFS_DEC  = 8'h14;
    localparam logic [2:0] CTRL_RST = 3'h0;

    // status bits
    localparam int STS_CLRSV = 0;
    localparam int STS_RCD   = 1;
    localparam int STS_RC    = 2;
    localparam int STS_RAS   = 3;

    // mode register address bit positions
    localparam int MR0_BL_LO = 0;
    localparam int MR0_BL_HI = 1;
    localparam int MR0_CL_LO = 2;
    localparam int MR0_BT    = 3;
    localparam int MR0_CL_A4 = 4;
    localparam int MR0_CL_A6 = 6;
    localparam int MR0_PPD   = 12;
    localparam int MR1_RTT_A2 = 2;
    localparam int MR1_RTT_A6 = 6;
    localparam int MR1_RTT_A9 = 9;
    localparam int MR1_QOFF  = 12;
    localparam int MR2_ASR   = 6;
    localparam int MR2_SRT   = 7;
    localparam int MR2_RWR_A9  = 9;
    localparam int MR2_RWR_A10 = 10;
    // address bit that widens a precharge to every bank
    localparam int PRE_ALL_BIT = 10;
    localparam logic [1:0] BL8_FIXED = 2'h0;
    localparam logic [2:0] RTT_NOM_ON = 3'h3;
    localparam logic [1:0] RTT_WR_ON  = 2'h2;

    // cas latency decode offsets and the burst length in link clocks
    localparam logic [3:0] CL_BASE_LO = 4'h4;
    localparam logic [3:0] CL_BASE_HI = 4'hc;
    localparam logic [3:0] CL_MIN  = 4'h6;
    localparam logic [3:0] CL_1600 = 4'hb;
    localparam logic [3:0] CL_1333 = 4'ha;
    localparam logic [3:0] CL_TOP  = 4'hd;
    localparam logic [2:0] BURST_CK = 3'h4;
endpackage : dts_pkg
`default_nettype wire

// *** dts_tmg_if.sv ***
// command events and timing flags between the decoder and the bank timer
`timescale 1ns/1ns
`default_nettype none
interface dts_tmg_if;
    logic       ev_act;    // activate seen
    logic       ev_pre;    // precharge seen
    logic       ev_pre_all;// precharge closes every bank
    logic       ev_rdwr;   // read or write seen
    logic       ev_ref;    // refresh seen
    logic [2:0] bank;      // bank of the event
    logic [1:0] grade;     // speed grade select
    logic       downbin;   // down-binned minima in force
    logic       viol_rcd;  // pulse: activate-to-column too soon
    logic       viol_rc;   // pulse: activate/refresh spacing too short
    logic       viol_ras;  // pulse: row open too short or too long
    modport ctl (output ev_act, ev_pre, ev_pre_all, ev_rdwr, ev_ref, bank, grade, downbin,
                 input viol_rcd, viol_rc, viol_ras);
    modport tmr (input ev_act, ev_pre, ev_pre_all, ev_rdwr, ev_ref, bank, grade, downbin,
                 output viol_rcd, viol_rc, viol_ras);
endinterface : dts_tmg_if
`default_nettype wire

// *** dts_bank_timer.sv ***
// per-bank row timers checking the controller's command spacing
`timescale 1ns/1ns
`default_nettype none
module dts_bank_timer
    import dts_pkg::*;
#(
    parameter logic [15:0] TRAS_MAX = 16'(dts_pkg::TRAS_MAX_CYC_DEF)
) (
    input wire logic hclk,
    input wire logic hresetn,
    dts_tmg_if.tmr   tif
);
    import dts_pkg::*;

    typedef struct packed {
        logic [7:0]       open;   // row open per bank
        logic [7:0]       seen;   // bank activated or refreshed before
        logic [7:0][15:0] cnt;    // cycles since last activate/refresh
        logic             rcd;
        logic             rc;
        logic             ras;
    } dts_bt_state_t;

    dts_bt_state_t q, d;

    // minima per grade; down-binned parts meet the tighter figure
    function automatic logic [15:0] t_rcd(input logic [1:0] g, input logic db);
        if (db) return CYC_DOWNBIN;
        else if (g == DTS_G1866) return CYC_RCD_1866;
        else if (g == DTS_G1600) return CYC_RCD_1600;
        else return CYC_RCD_1333;
    endfunction

    function automatic logic [15:0] t_rc(input logic [1:0] g);
        if (g == DTS_G1866) return CYC_RC_1866;
        else if (g == DTS_G1600) return CYC_RC_1600;
        else return CYC_RC_1333;
    endfunction

    // the fastest grade has no printed row minimum; it shares the 1600 figure
    function automatic logic [15:0] t_ras(input logic [1:0] g);
        if (g == DTS_G1333) return CYC_RAS_1333;
        else return CYC_RAS_1600;
    endfunction

    // next state: counters saturate so a long idle never wraps into a false hit
    always_comb begin
        d     = q;
        d.rcd = 1'b0;
        d.rc  = 1'b0;
        d.ras = 1'b0;
        for (int i = 0; i < 8; i++) begin
            if (q.cnt[i] != CNT_SAT) begin
                d.cnt[i] = q.cnt[i] + 16'h0001;
            end
        end
        // R9: activate to column
        if (tif.ev_rdwr && q.open[tif.bank] && q.cnt[tif.bank] < t_rcd(tif.grade, tif.downbin)) begin
            d.rcd = 1'b1;
        end
        // R10: same-bank activate spacing
        if (tif.ev_act) begin
            if (q.seen[tif.bank] && q.cnt[tif.bank] < t_rc(tif.grade)) begin
                d.rc = 1'b1;
            end
            d.open[tif.bank] = 1'b1;
            d.seen[tif.bank] = 1'b1;
            d.cnt[tif.bank]  = 16'h0000;
        end
        // R10: refresh counts as an activate on every bank
        if (tif.ev_ref) begin
            for (int i = 0; i < 8; i++) begin
                if (q.seen[i] && q.cnt[i] < t_rc(tif.grade)) begin
                    d.rc = 1'b1;
                end
                d.seen[i] = 1'b1;
                d.cnt[i]  = 16'h0000;
            end
        end
        // R11: row open window at precharge
        if (tif.ev_pre) begin
            for (int i = 0; i < 8; i++) begin
                if ((tif.ev_pre_all || tif.bank == 3'(i)) && q.open[i]) begin
                    if (q.cnt[i] < t_ras(tif.grade) || q.cnt[i] > TRAS_MAX) begin
                        d.ras = 1'b1;
                    end
                    d.open[i] = 1'b0;
                end
            end
        end
    end

    // state register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign tif.viol_rcd = q.rcd;
    assign tif.viol_rc  = q.rc;
    assign tif.viol_ras = q.ras;

    // back-to-back activate and column command can never meet the minimum
    a_rcd_too_soon: assert property (@(posedge hclk) disable iff (!hresetn) // R9
        (tif.ev_act ##1 (tif.ev_rdwr && tif.bank == $past(tif.bank))) |=> tif.viol_rcd)
        else $error("activate to column within one cycle not flagged");
    // activate, eight cycles with no precharge, then precharge of that bank:
    // the counter reads eight at the precharge, below every grade's nine-cycle minimum
    sequence s_short_row;
        tif.ev_act ##1 (!tif.ev_pre)[*8] ##1 (tif.ev_pre && tif.bank == $past(tif.bank, 9));
    endsequence
    a_ras_too_soon: assert property (@(posedge hclk) disable iff (!hresetn) // R11
        s_short_row |=> tif.viol_ras)
        else $error("short row open time not flagged");
endmodule : dts_bank_timer
`default_nettype wire

// *** dts_ddr3_setup.sv ***
// ddr3 device-side mode register capture, latency checks and read burst timing
//
// The address map and the AHB-Lite register port were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// R1: mr0 a1:a0 zero means fixed burst eight
// R2: mr1 a12 zero enables output buffer
// R3: mr1 a9,a6,a2 = 011 enables termination
// R4: mr2 a10:a9 = 10 enables write termination
// R5: mr0 a12 picks slow or fast exit
// R6: mr2 a6 enables auto self-refresh
// R7: mr2 a7 selects extended temperature range
// R8: mr0 a3 zero gives sequential burst
// R9: controller waits activate-to-column minimum
// R10: same-bank activate/refresh spacing minimum
// R11: row open between minimum and nine intervals
// R12: read data follows after cas latency; the code turns the drivers on at cas latency minus one link clocks
// R13: legal cas latencies depend on grade
// R14: latency six needs clock 2.5-3.3 ns
// R15: latency eleven needs clock 1.25-1.5 ns
// R16: latency thirteen needs clock 1.07-1.25 ns
// R17: clock meets cas and write limits
// R18: controller derives latency from access time
// R19: reserved latency settings must not occur
// R20: down-binned parts meet 13.125 ns minima
// R21: controller converts nanoseconds to rounded-up cycles
module dts_ddr3_setup
    import dts_pkg::*;
#(
    parameter logic [15:0] TRAS_MAX = 16'(dts_pkg::TRAS_MAX_CYC_DEF)
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    input  wire logic        ddr_ck,
    input  wire logic        ddr_cke,
    input  wire logic        ddr_cs_n,
    input  wire logic        ddr_ras_n,
    input  wire logic        ddr_cas_n,
    input  wire logic        ddr_we_n,
    input  wire logic [2:0]  ddr_ba,
    input  wire logic [15:0] ddr_addr,
    output logic             dq_oe,
    output logic             out_buf_en,
    output logic             rtt_nom_en,
    output logic             rtt_wr_en,
    output logic             pd_fast_exit,
    output logic             asr_en,
    output logic             srt_ext
);
    import dts_pkg::*;

    // read burst sequencer, one-hot
    typedef enum logic [2:0] {
        RD_IDLE  = 3'b001,
        RD_WAIT  = 3'b010,
        RD_BURST = 3'b100
    } dts_rd_t;

    typedef struct packed {
        logic [24:0] pin_s1;   // first synchroniser stage, read only by stage two
        logic [24:0] pin_s2;   // second synchroniser stage
        logic        ck_prev;  // last synchronised link clock level
        logic [15:0] mr0;
        logic [15:0] mr1;
        logic [15:0] mr2;
        logic [2:0]  ctrl;     // [1:0] grade, [2] down-bin
        logic [3:0]  sts;      // sticky flags, write one to clear
        logic [31:0] rdata;    // registered read data
        logic        wr_dp;    // write data phase pending
        logic [7:0]  wr_ofs;   // offset of that write
        dts_rd_t     rd;
        logic [3:0]  lat_cnt;  // link edges left before data
        logic [2:0]  bst_cnt;  // link edges left in the burst
        logic        oe;
    } dts_state_t;

    dts_state_t q, d;
    dts_tmg_if  tif ();

    // pin fields after synchronisation
    logic        ck_s, cke_s, cs_n_s, ras_n_s, cas_n_s, we_n_s;
    logic [2:0]  ba_s;
    logic [15:0] a_s;
    logic        ck_rise, cmd_ok, is_mrs, is_ref, is_pre, is_act, is_wr, is_rd;
    logic [3:0]  cl_q, cl_new;
    logic        ap_go, ap_rd;
    logic [7:0]  ap_ofs;
    logic [31:0] dec_word;
    logic [3:0]  sts_set, sts_clr;

    // cas latency from mr0 bits a6:a4 and a2
    function automatic logic [3:0] cl_of(input logic [15:0] mr);
        logic [3:0] f;
        f = {1'b0, mr[MR0_CL_A6:MR0_CL_A4]};
        return mr[MR0_CL_LO] ? (f + CL_BASE_HI) : (f + CL_BASE_LO);
    endfunction

    // latency allowed for the selected speed grade
    function automatic logic cl_legal(input logic [3:0] cl, input logic [1:0] g);
        if (cl < CL_MIN) return 1'b0;
        else if (g == DTS_G1866) return (cl <= CL_1600) || (cl == CL_TOP);
        else if (g == DTS_G1600) return cl <= CL_1600;
        else return cl <= CL_1333;
    endfunction

    assign {ck_s, cke_s, cs_n_s, ras_n_s, cas_n_s, we_n_s, ba_s, a_s} = q.pin_s2;
    assign ck_rise = ck_s && !q.ck_prev;
    // commands are taken on the link clock rising edge with cke high and select low
    assign cmd_ok  = ck_rise && cke_s && !cs_n_s;
    assign is_mrs  = cmd_ok && !ras_n_s && !cas_n_s && !we_n_s;
    assign is_ref  = cmd_ok && !ras_n_s && !cas_n_s && we_n_s;
    assign is_pre  = cmd_ok && !ras_n_s && cas_n_s && !we_n_s;
    assign is_act  = cmd_ok && !ras_n_s && cas_n_s && we_n_s;
    assign is_wr   = cmd_ok && ras_n_s && !cas_n_s && !we_n_s;
    assign is_rd   = cmd_ok && ras_n_s && !cas_n_s && we_n_s;
    assign cl_q    = cl_of(q.mr0);
    assign cl_new  = cl_of(a_s);

    // events and grade to the bank timer
    assign tif.ev_act     = is_act;
    assign tif.ev_pre     = is_pre;
    // a10 high turns a single precharge into precharge-all
    assign tif.ev_pre_all = a_s[PRE_ALL_BIT];
    assign tif.ev_rdwr    = is_rd || is_wr;
    assign tif.ev_ref     = is_ref;
    assign tif.bank       = ba_s;
    assign tif.grade      = q.ctrl[1:0];
    // R20: down-binned minima
    assign tif.downbin    = q.ctrl[2];

    dts_bank_timer #(
        .TRAS_MAX (TRAS_MAX)
    ) u_timer (
        .hclk    (hclk),
        .hresetn (hresetn),
        .tif     (tif.tmr)
    );

    // R5: power-down exit speed
    assign pd_fast_exit = q.mr0[MR0_PPD];
    // R2: output buffer on when a12 is zero
    assign out_buf_en   = !q.mr1[MR1_QOFF];
    // R3: nominal termination pattern
    assign rtt_nom_en   = {q.mr1[MR1_RTT_A9], q.mr1[MR1_RTT_A6], q.mr1[MR1_RTT_A2]} == RTT_NOM_ON;
    // R4: dynamic write termination pattern
    assign rtt_wr_en    = q.mr2[MR2_RWR_A10:MR2_RWR_A9] == RTT_WR_ON;
    // R6: auto self-refresh
    assign asr_en       = q.mr2[MR2_ASR];
    // R7: self-refresh temperature range
    assign srt_ext      = q.mr2[MR2_SRT];

    // decoded settings word for software
    // R1: fixed burst eight in bit zero
    // R8: sequential burst order in bit one
    assign dec_word = {20'h00000, cl_q, srt_ext, asr_en, rtt_wr_en, rtt_nom_en, out_buf_en,
                       pd_fast_exit, !q.mr0[MR0_BT],
                       q.mr0[MR0_BL_HI:MR0_BL_LO] == BL8_FIXED};

    // ahb address phase: zero wait states, so hsel, htrans[1] and hready qualify it
    assign ap_go  = hsel && htrans[1] && hready;
    assign ap_rd  = ap_go && !hwrite;
    assign ap_ofs = haddr[7:0];

    // R13: flag latencies outside the grade's set; mr0 still takes the setting
    // R19: reserved setting flagged
    always_comb begin
        sts_set = '0;
        sts_set[STS_CLRSV] = is_mrs && ba_s == 3'h0 && !cl_legal(cl_new, q.ctrl[1:0]);
        sts_set[STS_RCD]   = tif.viol_rcd;
        sts_set[STS_RC]    = tif.viol_rc;
        sts_set[STS_RAS]   = tif.viol_ras;
        sts_clr = (q.wr_dp && q.wr_ofs == OFS_STS) ? hwdata[3:0] : 4'h0;
    end

    // next state
    always_comb begin
        d         = q;
        d.pin_s1  = {ddr_ck, ddr_cke, ddr_cs_n, ddr_ras_n, ddr_cas_n, ddr_we_n, ddr_ba, ddr_addr};
        d.pin_s2  = q.pin_s1;
        d.ck_prev = ck_s;
        // mode register set: bank address selects the register
        if (is_mrs) begin
            if (ba_s == 3'h0) begin
                d.mr0 = a_s;
            end else if (ba_s == 3'h1) begin
                d.mr1 = a_s;
            end else if (ba_s == 3'h2) begin
                d.mr2 = a_s;
            end
        end
        // a set arriving with its clear wins
        d.sts   = (q.sts & ~sts_clr) | sts_set;
        // write data phase; only the control register stores write data, status takes write-one-to-clear
        d.wr_dp = ap_go && hwrite;
        d.wr_ofs = ap_ofs;
        if (q.wr_dp && q.wr_ofs == OFS_CTRL) begin
            d.ctrl = hwdata[2:0];
        end
        // read data captured in the address phase, unmapped reads give zero
        if (ap_rd) begin
            if (ap_ofs == OFS_CTRL) begin
                d.rdata = {29'h0, q.ctrl};
            end else if (ap_ofs == OFS_MR0) begin
                d.rdata = {16'h0000, q.mr0};
            end else if (ap_ofs == OFS_MR1) begin
                d.rdata = {16'h0000, q.mr1};
            end else if (ap_ofs == OFS_MR2) begin
                d.rdata = {16'h0000, q.mr2};
            end else if (ap_ofs == OFS_STS) begin
                d.rdata = {28'h0, q.sts};
            end else if (ap_ofs == OFS_DEC) begin
                d.rdata = dec_word;
            end else begin
                d.rdata = 32'h0;
            end
        end
        // R12: drivers turn on cas latency minus one link clocks after the read
        case (q.rd)
            RD_IDLE: begin
                if (is_rd) begin
                    d.rd      = RD_WAIT;
                    d.lat_cnt = cl_q - 4'h1;
                end
            end
            RD_WAIT: begin
                if (ck_rise) begin
                    if (q.lat_cnt == 4'h1) begin
                        d.rd      = RD_BURST;
                        d.bst_cnt = BURST_CK;
                        // R2: drivers stay off when the buffer is disabled
                        d.oe      = out_buf_en;
                    end else begin
                        d.lat_cnt = q.lat_cnt - 4'h1;
                    end
                end
            end
            RD_BURST: begin
                if (ck_rise) begin
                    if (q.bst_cnt == 3'h1) begin
                        d.rd = RD_IDLE;
                        d.oe = 1'b0;
                    end else begin
                        d.bst_cnt = q.bst_cnt - 3'h1;
                    end
                end
            end
            default: begin
                d.rd = RD_IDLE;
                d.oe = 1'b0;
            end
        endcase
    end

    // state register; reset values are constants only
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            q      <= '0;
            q.ctrl <= CTRL_RST;
            q.rd   <= RD_IDLE;
        end else begin
            q <= d;
        end
    end

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = q.rdata;
    assign dq_oe     = q.oe;

    // slave never stalls and never errors
    a_ahb_okay: assert property (@(posedge hclk) disable iff (!hresetn)
        hreadyout && !hresp)
        else $error("slave answered with wait or error");
    // mode register 1 takes the address of its set command
    a_mrs_store: assert property (@(posedge hclk) disable iff (!hresetn) // R2
        (is_mrs && ba_s == 3'h1) |=> (q.mr1 == $past(a_s)))
        else $error("mode register 1 not loaded");
    // illegal latency for the grade raises the sticky flag
    a_cl_reserved: assert property (@(posedge hclk) disable iff (!hresetn) // R19
        (is_mrs && ba_s == 3'h0 && !cl_legal(cl_new, q.ctrl[1:0])) |=> q.sts[STS_CLRSV])
        else $error("reserved latency not flagged");
    // drivers turn on only while the buffer is enabled
    a_qoff_gate: assert property (@(posedge hclk) disable iff (!hresetn) // R2
        $rose(dq_oe) |-> out_buf_en && $past(q.rd == RD_WAIT))
        else $error("output enabled with buffer off");
    // read wait reaches the burst only on its last counted edge
    sequence s_last_wait;
        q.rd == RD_WAIT && q.lat_cnt == 4'h1 && ck_rise;
    endsequence
    a_read_start: assert property (@(posedge hclk) disable iff (!hresetn) // R12
        s_last_wait |=> (q.rd == RD_BURST && q.bst_cnt == BURST_CK))
        else $error("burst did not start after latency");
    // flag set by hardware survives a simultaneous clear
    a_set_wins: assert property (@(posedge hclk) disable iff (!hresetn) // R10
        tif.viol_rc |=> q.sts[STS_RC])
        else $error("activate spacing flag lost");
endmodule : dts_ddr3_setup
`default_nettype wire

// *** dts_ctl_model.sv ***
// controller-side model that drives the ddr3 command and address pins
`timescale 1ns/1ns
`default_nettype none
module dts_ctl_model (
    output logic        ck,
    output logic        cke,
    output logic        cs_n,
    output logic [2:0]  cmd_n,
    output logic [2:0]  ba,
    output logic [15:0] addr,
    input  wire logic   hclk
);
    // link idle: clock parked low, device deselected
    initial begin
        ck    = 1'b0;
        cke   = 1'b1;
        cs_n  = 1'b1;
        cmd_n = 3'h7;
        ba    = 3'h0;
        addr  = 16'h0000;
    end
    // one command per ck rise; the clock only runs inside a frame
    // rises 31 hclk apart exceed every rounded-up minimum
    task automatic issue(input logic sel, input logic [2:0] c, input logic [2:0] b,
                         input logic [15:0] a);
        @(posedge hclk);
        cs_n  <= ~sel;
        cmd_n <= c;
        ba    <= b;
        addr  <= a;
        repeat (8) @(posedge hclk);
        ck <= 1'b1;
        repeat (16) @(posedge hclk);
        ck <= 1'b0;
        repeat (6) @(posedge hclk);
        // released pins show the inverse so stale values cannot pass
        cs_n  <= 1'b1;
        cmd_n <= ~c;
        ba    <= ~b;
        addr  <= ~a;
    endtask
    // short frame: rises 9 hclk apart, deliberately inside the spacing minima
    // so the device's violation flags can be exercised; pins lead the rise by 3 hclk and hold 5 hclk after it
    task automatic quick(input logic [2:0] c, input logic [2:0] b, input logic [15:0] a);
        @(posedge hclk);
        cs_n  <= 1'b0;
        cmd_n <= c;
        ba    <= b;
        addr  <= a;
        repeat (3) @(posedge hclk);
        ck <= 1'b1;
        repeat (3) @(posedge hclk);
        ck <= 1'b0;
        repeat (2) @(posedge hclk);
        cs_n  <= 1'b1;
        cmd_n <= ~c;
        ba    <= ~b;
        addr  <= ~a;
    endtask
endmodule // dts_ctl_model
`default_nettype wire

// *** test_ddr3_timing_and_mode_setup.sv ***
// self-checking bench: register bus tasks plus command sequences on the link
`timescale 1ns/1ns
`default_nettype none
module test_ddr3_timing_and_mode_setup;
    import dts_pkg::*;
    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, dq_oe;
    logic [1:0]  htrans;
    logic [31:0] haddr, hwdata, hrdata, d;
    logic        ck, cke, cs_n, obuf, rnom, rwr, pdx, asr, srt;
    logic [2:0]  cmd_n, ba;
    logic [15:0] addr;
    int          miscompares, n_compared;
    // small row-open ceiling so the long-open case fits the run
    dts_ddr3_setup #(.TRAS_MAX(16'h00c8)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .ddr_ck(ck), .ddr_cke(cke), .ddr_cs_n(cs_n), .ddr_ras_n(cmd_n[2]),
        .ddr_cas_n(cmd_n[1]), .ddr_we_n(cmd_n[0]), .ddr_ba(ba), .ddr_addr(addr),
        .dq_oe(dq_oe), .out_buf_en(obuf), .rtt_nom_en(rnom), .rtt_wr_en(rwr),
        .pd_fast_exit(pdx), .asr_en(asr), .srt_ext(srt));
    dts_ctl_model mdl (.ck(ck), .cke(cke), .cs_n(cs_n), .cmd_n(cmd_n), .ba(ba),
        .addr(addr), .hclk(hclk));
    // 250 mhz system clock
    initial begin
        hclk = 1'b0;
        forever #2 hclk = ~hclk;
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        n_compared++;
        if (s !== e) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", nm, e, s);
        end
    endtask
    // ahb single transfer: hold address phase until hready, then data phase;
    // select stays up afterwards, idle htrans keeps the slave quiet
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
                        output logic [31:0] rd);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr  <= {24'h0, a};
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask
    // read command, then ten quiet rises; the drive window covers rises 5..8
    task automatic burst(input logic on);
        mdl.issue(1'b1, 3'h5, 3'h0, 16'h0000);
        for (int i = 1; i <= 10; i++) begin
            mdl.issue(1'b0, 3'h7, 3'h0, 16'h0000);
            chk("dq_oe", {31'h0, on && i >= 5 && i <= 8}, {31'h0, dq_oe});
        end
    endtask
    task automatic wrap_up;
        if (miscompares == 0 && n_compared > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // watchdog well beyond the roughly 1000 cycles the tests need
    initial begin
        repeat (20000) @(posedge hclk);
        miscompares++;
        wrap_up();
    end
    initial begin
        miscompares = 0;
        n_compared  = 0;
        hresetn = 1'b0;
        hsel    = 1'b0;
        htrans  = 2'h0;
        hwrite  = 1'b0;
        haddr   = 32'h0;
        hwdata  = 32'h0;
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (4) @(posedge hclk);
        xfer(1'b0, OFS_DEC, 32'h0, d);
        chk("dec_reset", 32'h0000000b, {24'h0, d[7:0]});
        // cas latency six, legal on every grade
        mdl.issue(1'b1, 3'h0, 3'h0, 16'h1020);
        xfer(1'b0, OFS_MR0, 32'h0, d);
        chk("mr0", 32'h00001020, d);
        xfer(1'b0, OFS_DEC, 32'h0, d);
        chk("dec_mr0", 32'h0000060f, {20'h0, d[11:0]});
        chk("pd_fast_exit", 32'h1, {31'h0, pdx});
        mdl.issue(1'b1, 3'h0, 3'h1, 16'h0044);
        chk("mr1_bits", 32'h3, {30'h0, obuf, rnom});
        mdl.issue(1'b1, 3'h0, 3'h2, 16'h04c0);
        chk("mr2_bits", 32'h7, {29'h0, rwr, asr, srt});
        mdl.issue(1'b1, 3'h3, 3'h0, 16'h0012);
        burst(1'b1);
        mdl.issue(1'b1, 3'h0, 3'h1, 16'h1044);
        chk("out_buf_off", 32'h0, {31'h0, obuf});
        burst(1'b0);
        mdl.issue(1'b1, 3'h2, 3'h0, 16'h0000);
        xfer(1'b0, OFS_STS, 32'h0, d);
        chk("sts_ras_max", 32'h00000008, d);
        xfer(1'b1, OFS_STS, 32'h0000000f, d);
        xfer(1'b0, OFS_STS, 32'h0, d);
        chk("sts_clear", 32'h0, d);
        xfer(1'b1, OFS_CTRL, 32'h00000002, d);
        xfer(1'b0, OFS_CTRL, 32'h0, d);
        chk("ctrl", 32'h00000002, d);
        // latency eleven is reserved on the slowest grade
        mdl.issue(1'b1, 3'h0, 3'h0, 16'h0070);
        xfer(1'b0, OFS_STS, 32'h0, d);
        chk("sts_bad_cl", 32'h00000001, d);
        // short frames: second activate and its precharge both come too soon
        mdl.quick(3'h3, 3'h2, 16'h0000);
        mdl.quick(3'h3, 3'h2, 16'h0000);
        mdl.quick(3'h2, 3'h2, 16'h0000);
        xfer(1'b0, OFS_STS, 32'h0, d);
        chk("sts_spacing", 32'h0000000d, d);
        xfer(1'b0, 8'h40, 32'h0, d);
        chk("unmapped", 32'h0, d);
        wrap_up();
    end
endmodule // test_ddr3_timing_and_mode_setup
`default_nettype wire
